// file: src/accel_reader_map.vh
// Constants for the three-wire accelerometer reader
`ifndef ACCEL_READER_MAP_VH
`define ACCEL_READER_MAP_VH

// Clock rates
`define CORE_CLK_HZ 125000000
`define CTRL_CLK_HZ 10000000

// Sensor register addresses (six address bits)
`define REG_RATE 6'h2C
`define REG_INT_SOURCE 6'h30
`define REG_FORMAT 6'h31
`define REG_AXIS_FIRST 6'h32

// Command byte fields
`define CMD_READ_BIT 7
`define CMD_MULTI_BIT 6

// Format register field positions
`define FMT_SELFTEST_BIT 7
`define FMT_WIRE_BIT 6
`define FMT_INT_INV_BIT 5
`define FMT_FULLRES_BIT 3
`define FMT_JUSTIFY_BIT 2
`define FMT_RANGE_LSB 0

// Format field values: 10-bit, right-justified, +/-2 g
`define FMT_WIRE_3 8'h01
`define FMT_FULLRES_OFF 8'h00
`define FMT_JUSTIFY_RIGHT 8'h00
`define FMT_RANGE_2G 8'h00

// Rate register value for 400 Hz output
`define RATE_400HZ 8'h0C

// Interrupt-source sample-ready flag
`define INT_READY_BIT 7

// Frame lengths in bits
`define LEN_CMD 6'h08
`define LEN_SHORT 6'h10
`define LEN_BURST 6'h38

// Reset values
`define RST_INT_SOURCE 8'h00
`define RST_AXIS 16'h0000

`endif

// file: src/sample_fifo.v
// Parameterised flip-flop FIFO carrying assembled axis samples
`default_nettype none

module sample_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_sys_rst,
    // Fill side
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);

    localparam [AW:0] FULL_CNT = DEPTH[AW:0];

    reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage
    reg [AW-1:0] wr_ptr_r; // Next slot to fill
    reg [AW-1:0] rd_ptr_r; // Oldest entry
    reg [AW:0] count_r; // Entries held

    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_in_ready = (count_r != FULL_CNT);
    assign o_out_valid = (count_r != {(AW+1){1'b0}});
    assign o_out_data = mem_r[rd_ptr_r];

    // Storage write, no reset needed on data
    always @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers and occupancy
    always @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // sample_fifo

`default_nettype wire

// file: src/accel_three_wire_spi_reader.v
// Three-wire serial reader for a three-axis accelerometer
//
// Functional notes
// - Set wire-mode bit before any sample read
// - Format: 10-bit, right-justified, plus/minus 2g
// - Program 400 Hz output rate at start
// - Poll interrupt source until sample ready
// - Read six axis bytes in one burst
// - Axis words: low byte first, two's complement
// - Serial clock idles high between transfers
// - Drive on falling edge, sample on rising
// - Controller steps at 10 MHz rate; code divides 125 MHz by 12, so it steps at about 10.4 MHz
`include "accel_reader_map.vh"
`default_nettype none

module accel_three_wire_spi_reader #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_sys_rst,
    // Control and status
    input wire i_enable,
    output wire o_cfg_done,
    output wire o_busy,
    output wire [7:0] o_int_source,
    // Sensor pins
    output wire o_sclk,
    output wire o_cs_n,
    output wire o_sdio,
    output wire o_sdio_oe,
    input wire i_sdio,
    // Sample stream
    output wire o_sample_valid,
    input wire i_sample_ready,
    output wire [15:0] o_sample_x,
    output wire [15:0] o_sample_y,
    output wire [15:0] o_sample_z
);

    // Controller step: core cycles per 10 MHz tick, rounded down
    localparam integer TICK_CYC = `CORE_CLK_HZ / `CTRL_CLK_HZ;
    localparam [7:0] TICK_LAST = TICK_CYC[7:0] - 8'h01;

    // Sequencer states
    localparam [2:0] ST_FMT = 3'h0;
    localparam [2:0] ST_RATE = 3'h1;
    localparam [2:0] ST_POLL = 3'h2;
    localparam [2:0] ST_ROOM = 3'h3;
    localparam [2:0] ST_BURST = 3'h4;

    // Shift engine phases
    localparam [1:0] PH_IDLE = 2'h0;
    localparam [1:0] PH_SHIFT = 2'h1;
    localparam [1:0] PH_END = 2'h2;

    // Format byte built from its fields
    localparam [7:0] FMT_VAL = (`FMT_WIRE_3 << `FMT_WIRE_BIT)
        | (`FMT_FULLRES_OFF << `FMT_FULLRES_BIT)
        | (`FMT_JUSTIFY_RIGHT << `FMT_JUSTIFY_BIT)
        | (`FMT_RANGE_2G << `FMT_RANGE_LSB);

    // Command bytes
    localparam [7:0] CMD_WR_FMT = {2'b00, `REG_FORMAT};
    localparam [7:0] CMD_WR_RATE = {2'b00, `REG_RATE};
    localparam [7:0] CMD_RD_INT = (8'h01 << `CMD_READ_BIT) | {2'b00, `REG_INT_SOURCE};
    localparam [7:0] CMD_RD_AXES = (8'h01 << `CMD_READ_BIT)
        | (8'h01 << `CMD_MULTI_BIT) | {2'b00, `REG_AXIS_FIRST};

    reg [7:0] tick_cnt_r; // Divider for controller tick
    reg tick_r; // One-cycle tick pulse
    reg sdio_meta_r; // First sync stage, read only by next
    reg sdio_sync_r; // Synchronised data input
    reg [2:0] state_r; // Sequencer state
    reg [1:0] ph_r; // Engine phase
    reg half_r; // Low or high half of a bit
    reg [5:0] bit_cnt_r; // Bit index in frame
    reg [5:0] len_r; // Frame length in bits
    reg [5:0] wlen_r; // Bits driven by us
    reg [55:0] sh_r; // Outgoing shift register
    reg [47:0] rx_r; // Incoming shift register
    reg sclk_r; // Serial clock pin
    reg cs_n_r; // Chip select pin
    reg sdio_r; // Data pin value
    reg sdio_oe_r; // Data pin enable
    reg cfg_done_r; // Configuration finished
    reg [7:0] int_src_r; // Last interrupt-source byte
    reg [15:0] x_r; // Assembled X
    reg [15:0] y_r; // Assembled Y
    reg [15:0] z_r; // Assembled Z
    reg push_r; // Push strobe into FIFO

    reg [55:0] frame_nxt; // Frame for current state
    reg [5:0] len_nxt; // Its length
    reg [5:0] wlen_nxt; // Its driven part
    reg go_nxt; // A transaction may start

    wire fifo_in_ready; // FIFO has a free slot
    wire [47:0] fifo_out_data; // Oldest sample

    // Tick divider; sensor clock toggles once per tick while a frame shifts
    always @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tick_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r == TICK_LAST)
        begin
            tick_cnt_r <= 8'h00;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // Two-flop synchroniser for the data pin
    always @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sdio_meta_r <= 1'b0;
            sdio_sync_r <= 1'b0;
        end
        else
        begin
            sdio_meta_r <= i_sdio;
            sdio_sync_r <= sdio_meta_r;
        end
    end

    // Frame choice per sequencer state
    always @*
    begin
        frame_nxt = 56'h0;
        len_nxt = `LEN_SHORT;
        wlen_nxt = `LEN_SHORT;
        go_nxt = 1'b0;
        case (state_r)
            ST_FMT:
            begin
                // Wire mode and format go first
                frame_nxt = {CMD_WR_FMT, FMT_VAL, 40'h0};
                go_nxt = 1'b1;
            end
            ST_RATE:
            begin
                frame_nxt = {CMD_WR_RATE, `RATE_400HZ, 40'h0};
                go_nxt = 1'b1;
            end
            ST_POLL:
            begin
                // Single read of the flag register
                frame_nxt = {CMD_RD_INT, 48'h0};
                wlen_nxt = `LEN_CMD;
                go_nxt = i_enable;
            end
            ST_BURST:
            begin
                // One command, six bytes back
                frame_nxt = {CMD_RD_AXES, 48'h0};
                len_nxt = `LEN_BURST;
                wlen_nxt = `LEN_CMD;
                go_nxt = 1'b1;
            end
            default:
            begin
                go_nxt = 1'b0;
            end
        endcase
    end

    // Sequencer and shift engine
    always @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_r <= ST_FMT;
            ph_r <= PH_IDLE;
            half_r <= 1'b0;
            bit_cnt_r <= 6'h00;
            len_r <= `LEN_SHORT;
            wlen_r <= `LEN_SHORT;
            sh_r <= 56'h0;
            rx_r <= 48'h0;
            sclk_r <= 1'b1;
            cs_n_r <= 1'b1;
            sdio_r <= 1'b0;
            sdio_oe_r <= 1'b0;
            cfg_done_r <= 1'b0;
            int_src_r <= `RST_INT_SOURCE;
            x_r <= `RST_AXIS;
            y_r <= `RST_AXIS;
            z_r <= `RST_AXIS;
            push_r <= 1'b0;
        end
        else
        begin
            push_r <= 1'b0;
            if (tick_r)
            begin
                case (ph_r)
                    PH_IDLE:
                    begin
                        // Wait for FIFO space so a burst is never dropped
                        if (state_r == ST_ROOM)
                        begin
                            if (fifo_in_ready)
                            begin
                                state_r <= ST_BURST;
                            end
                        end
                        else if (go_nxt)
                        begin
                            cs_n_r <= 1'b0;
                            sh_r <= frame_nxt;
                            len_r <= len_nxt;
                            wlen_r <= wlen_nxt;
                            bit_cnt_r <= 6'h00;
                            half_r <= 1'b0;
                            ph_r <= PH_SHIFT;
                        end
                    end
                    PH_SHIFT:
                    begin
                        if (!half_r)
                        begin
                            // Falling edge: present next bit
                            sclk_r <= 1'b0;
                            sdio_r <= sh_r[55];
                            sdio_oe_r <= (bit_cnt_r < wlen_r);
                            half_r <= 1'b1;
                        end
                        else
                        begin
                            // Rising edge: capture the sensor's bit
                            sclk_r <= 1'b1;
                            sh_r <= {sh_r[54:0], 1'b0};
                            if (bit_cnt_r >= wlen_r)
                            begin
                                rx_r <= {rx_r[46:0], sdio_sync_r};
                            end
                            half_r <= 1'b0;
                            if (bit_cnt_r == len_r - 6'h01)
                            begin
                                ph_r <= PH_END;
                            end
                            else
                            begin
                                bit_cnt_r <= bit_cnt_r + 6'h01;
                            end
                        end
                    end
                    PH_END:
                    begin
                        // Clock already high; release select and pin
                        cs_n_r <= 1'b1;
                        sdio_oe_r <= 1'b0;
                        ph_r <= PH_IDLE;
                        case (state_r)
                            ST_FMT:
                            begin
                                state_r <= ST_RATE;
                            end
                            ST_RATE:
                            begin
                                state_r <= ST_POLL;
                                cfg_done_r <= 1'b1;
                            end
                            ST_POLL:
                            begin
                                int_src_r <= rx_r[7:0];
                                if (rx_r[`INT_READY_BIT])
                                begin
                                    state_r <= ST_ROOM;
                                end
                            end
                            ST_BURST:
                            begin
                                // Low register byte is the low half
                                x_r <= {rx_r[39:32], rx_r[47:40]};
                                y_r <= {rx_r[23:16], rx_r[31:24]};
                                z_r <= {rx_r[7:0], rx_r[15:8]};
                                push_r <= 1'b1;
                                state_r <= ST_POLL;
                            end
                            default:
                            begin
                                state_r <= ST_POLL;
                            end
                        endcase
                    end
                    default:
                    begin
                        ph_r <= PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Space was checked before the burst, so the push always lands
    sample_fifo #(
        .WIDTH(48),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(push_r),
        .o_in_ready(fifo_in_ready),
        .i_in_data({z_r, y_r, x_r}),
        .o_out_valid(o_sample_valid),
        .i_out_ready(i_sample_ready),
        .o_out_data(fifo_out_data)
    );

    // Outputs
    assign o_sclk = sclk_r;
    assign o_cs_n = cs_n_r;
    assign o_sdio = sdio_r;
    assign o_sdio_oe = sdio_oe_r;
    assign o_cfg_done = cfg_done_r;
    assign o_busy = (ph_r != PH_IDLE);
    assign o_int_source = int_src_r;
    assign o_sample_x = fifo_out_data[15:0];
    assign o_sample_y = fifo_out_data[31:16];
    assign o_sample_z = fifo_out_data[47:32];

endmodule // accel_three_wire_spi_reader

`default_nettype wire

// file: tb/accel_reader_chk.sv
// Link and stream checker for the accelerometer reader
`default_nettype none
module accel_reader_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Status
    input wire logic o_cfg_done,
    input wire logic o_busy,
    // Sensor pins
    input wire logic o_sclk,
    input wire logic o_cs_n,
    input wire logic o_sdio,
    input wire logic o_sdio_oe,
    // Sample stream
    input wire logic o_sample_valid,
    input wire logic i_sample_ready,
    input wire logic [15:0] o_sample_x,
    input wire logic [15:0] o_sample_y,
    input wire logic [15:0] o_sample_z
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_r; // Serial clock one cycle ago
    logic [6:0] bit_cnt_r; // Falling edges in this frame

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Count bits per frame; cleared while deselected
    always @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sclk_r <= 1'b1;
            bit_cnt_r <= 7'h00;
        end
        else
        begin
            sclk_r <= o_sclk;
            if (o_cs_n)
                bit_cnt_r <= 7'h00;
            else if (sclk_r && !o_sclk)
                bit_cnt_r <= bit_cnt_r + 7'h01;
        end
    end

    a_idle_clk_high:
        assert property (o_cs_n |-> o_sclk) else $error("Clock low while deselected");
    a_first_fall:
        assert property ($fell(o_cs_n) |-> o_sclk ##12 $fell(o_sclk)) else $error("First clock fall late");
    a_low_phase:
        assert property ($fell(o_sclk) |-> ##12 $rose(o_sclk)) else $error("Clock low phase wrong");
    a_high_phase:
        assert property ($rose(o_sclk) |-> ##12 ($fell(o_sclk) || o_cs_n)) else $error("Clock high phase wrong");
    a_drive_on_fall:
        assert property (!o_cs_n && !$past(o_cs_n) && $stable(o_sclk) |-> $stable({o_sdio, o_sdio_oe}))
        else $error("Data moved off the falling edge");
    a_oe_in_frame:
        assert property (o_sdio_oe |-> !o_cs_n) else $error("Pin driven while deselected");
    a_frame_length:
        assert property ($rose(o_cs_n) |-> (bit_cnt_r == 7'h10 || bit_cnt_r == 7'h38))
        else $error("Frame length wrong");
    a_cs_gap:
        assert property ($rose(o_cs_n) |-> o_cs_n [*8]) else $error("Select gap too short");
    a_cfg_first:
        assert property ($rose(o_cs_n) && bit_cnt_r == 7'h38 |-> o_cfg_done) else $error("Burst before config");
    a_busy_frame:
        assert property (!o_cs_n |-> o_busy) else $error("Busy low in frame");
    a_push_burst:
        assert property ($rose(o_cs_n) && bit_cnt_r == 7'h38 |-> ##[1:3] o_sample_valid)
        else $error("Burst not pushed");
    a_head_hold:
        assert property (o_sample_valid && !i_sample_ready |=> o_sample_valid
            && $stable({o_sample_z, o_sample_y, o_sample_x})) else $error("Head sample moved");

    c_poll_end: cover property ($rose(o_cs_n) && bit_cnt_r == 7'h10);
    c_burst_end: cover property ($rose(o_cs_n) && bit_cnt_r == 7'h38);
    c_pop: cover property (o_sample_valid && i_sample_ready);
endmodule // accel_reader_chk

bind accel_three_wire_spi_reader accel_reader_chk accel_reader_chk_inst (.*);
`default_nettype wire

// file: tb/accel_sensor_model.sv
// Behavioural three-wire accelerometer at the far end of the link
`include "accel_reader_map.vh"
`default_nettype none
module accel_sensor_model (
    // Link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_pin,
    // Sensor data drive
    output var logic o_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [0:63]; // Register file
    logic [7:0] cmd; // Command byte
    logic [7:0] wbyte; // Write data
    int cnt; // Bits in frame
    int n_read; // Read frames
    int n_burst; // Axis bursts
    int n_early; // Reads before wire mode set

    initial
    begin
        foreach (regs[i])
            regs[i] = 8'h00;
        cmd = 8'h00;
        wbyte = 8'h00;
        o_drive = 1'b0;
        cnt = 0;
        n_read = 0;
        n_burst = 0;
        n_early = 0;
    end

    // Capture on the rising edge, MSB first
    always @(posedge i_sclk)
    begin
        if (!i_cs_n)
        begin
            if (cnt < 8)
                cmd = {cmd[6:0], i_pin};
            else if (!cmd[7])
                wbyte = {wbyte[6:0], i_pin};
            cnt = cnt + 1;
            if (cnt == 16 && !cmd[7])
                regs[cmd[5:0]] = wbyte;
        end
    end

    // Launch read data on the falling edge; multi-byte walks up the map
    always @(negedge i_sclk)
    begin
        if (!i_cs_n && cnt >= 8 && cmd[7])
            o_drive <= regs[cmd[5:0] + (cmd[6] ? (cnt - 8) / 8 : 0)][7 - (cnt % 8)];
    end

    // Released line shows the inverse so a stale bit cannot pass
    always @(posedge i_cs_n)
    begin
        o_drive <= ~o_drive;
        if (cnt > 8 && cmd[7])
        begin
            n_read = n_read + 1;
            if (!regs[`REG_FORMAT][6])
                n_early = n_early + 1;
            if (cmd[6] && cmd[5:0] == `REG_AXIS_FIRST && cnt == 56)
            begin
                n_burst = n_burst + 1;
                // Lets the bench tell successive samples apart
                regs[`REG_AXIS_FIRST] = regs[`REG_AXIS_FIRST] + 8'h01;
            end
        end
        cnt = 0;
    end
endmodule // accel_sensor_model
`default_nettype wire

// file: tb/accel_three_wire_spi_reader_test.sv
// Self-checking bench for the three-wire accelerometer reader
`include "accel_reader_map.vh"
`default_nettype none
module accel_three_wire_spi_reader_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // Core clock
    logic rst = 1'b1; // Reset
    logic en = 1'b0; // Poll enable
    logic rdy = 1'b0; // Consumer ready
    logic done, busy, sclk, cs_n, sdio, oe, drive, valid;
    logic [7:0] isrc; // Interrupt source seen
    logic [15:0] sx, sy, sz; // Head sample
    wire pin = oe ? sdio : drive; // Resolved data pin
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    accel_three_wire_spi_reader accel_three_wire_spi_reader_inst (
        .i_core_clk(clk), .i_sys_rst(rst), .i_enable(en), .o_cfg_done(done), .o_busy(busy),
        .o_int_source(isrc), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio), .o_sdio_oe(oe),
        .i_sdio(pin), .o_sample_valid(valid), .i_sample_ready(rdy),
        .o_sample_x(sx), .o_sample_y(sy), .o_sample_z(sz)
    );
    accel_sensor_model accel_sensor_model_inst (.i_sclk(sclk), .i_cs_n(cs_n), .i_pin(pin), .o_drive(drive));

    // 125 MHz core clock
    always #4 clk = ~clk;

    // Verdict and end of run
    task test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Compare one value, log a mismatch
    task check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pins idle while reset is held
    task t_reset;
        repeat (9) @(posedge clk);
        #1 check_val("idle pins", 16'h000C, {12'h000, sclk, cs_n, oe, valid});
    endtask

    // Config runs by itself; no reads while disabled
    task t_config;
        for (int i = 0; i < 4000 && done !== 1'b1; i++)
            @(posedge clk);
        check_val("cfg done", 16'h0001, {15'h0000, done});
        check_val("format", 16'h0040, {8'h00, accel_sensor_model_inst.regs[`REG_FORMAT]});
        check_val("rate", {8'h00, `RATE_400HZ}, {8'h00, accel_sensor_model_inst.regs[`REG_RATE]});
        repeat (1000) @(posedge clk);
        check_val("reads disabled", 16'h0000, accel_sensor_model_inst.n_read[15:0]);
    endtask

    // Flags without ready never lead to a burst
    task t_poll;
        accel_sensor_model_inst.regs[`REG_INT_SOURCE] = 8'h11;
        en <= 1'b1;
        repeat (2000) @(posedge clk);
        check_val("int source", 16'h0011, {8'h00, isrc});
        check_val("no burst", 16'h0000, accel_sensor_model_inst.n_burst[15:0]);
    endtask

    // Six-byte burst, low byte first, signed words
    task t_burst;
        logic [7:0] b [6] = '{8'h34, 8'hFF, 8'h02, 8'h01, 8'h80, 8'h00};
        for (int k = 0; k < 6; k++)
            accel_sensor_model_inst.regs[`REG_AXIS_FIRST + k] = b[k];
        accel_sensor_model_inst.regs[`REG_INT_SOURCE] = 8'h80;
        for (int i = 0; i < 3000 && valid !== 1'b1; i++)
            @(posedge clk);
        check_val("x", 16'hFF34, sx);
        check_val("y", 16'h0102, sy);
        check_val("z", 16'h0080, sz);
    endtask

    // Stalled consumer fills the buffer, link goes quiet
    task t_full;
        int reads;
        for (int i = 0; i < 40000 && accel_sensor_model_inst.n_burst < 16; i++)
            @(posedge clk);
        // One more poll follows the last burst; it sees ready, then the loop stalls
        repeat (1000) @(posedge clk);
        reads = accel_sensor_model_inst.n_read;
        repeat (3000) @(posedge clk);
        check_val("reads when full", reads[15:0], accel_sensor_model_inst.n_read[15:0]);
        check_val("bursts", 16'h0010, accel_sensor_model_inst.n_burst[15:0]);
        check_val("early reads", 16'h0000, accel_sensor_model_inst.n_early[15:0]);
    endtask

    // Back-to-back pops drain sixteen samples in order
    task t_drain;
        accel_sensor_model_inst.regs[`REG_INT_SOURCE] = 8'h00;
        rdy <= 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            @(negedge clk);
            check_val("head x", {8'hFF, 8'h34 + k[7:0]}, sx);
        end
        @(posedge clk);
        rdy <= 1'b0;
        @(negedge clk);
        check_val("drained", 16'h0000, {15'h0000, valid});
    endtask

    // Main sequence
    initial
    begin
        t_reset;
        @(posedge clk);
        rst <= 1'b0;
        t_config;
        t_poll;
        t_burst;
        t_full;
        t_drain;
        test_done;
    end

    // Cycle ceiling against a hung link
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            bad_count++;
            test_done;
        end
    end
endmodule // accel_three_wire_spi_reader_test
`default_nettype wire
